//--- design/tofc_pkg.sv
// Package for the timer output, flag and interrupt/DMA mask block.
// Assumes an APB slave with 32-bit data; registers are byte-wide in bit 7:0.
package tofc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DMA_COUNTER_POINTER = 8'hf0;
  localparam logic [7:0] IDX_PIN_A_SWAP_CTRL = 8'hf1;
  localparam logic [7:0] IDX_OUTPUT_B_CONTROL = 8'hfd;
  localparam logic [7:0] IDX_TIMER_EVENT_FLAGS = 8'hfe;
  localparam logic [7:0] IDX_IRQ_DMA_MASK = 8'hff;
  localparam int ADDR_W = 12;

  // Reset values
  localparam logic [7:0] RST_OUTPUT_B_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_DMA_MASK = 8'h00;
  localparam logic [7:0] RST_DMA_COUNTER_POINTER = 8'h00;
  localparam logic [7:0] RST_PIN_A_SWAP_CTRL = 8'h00;

  // Output B control fields
  localparam int OB_CMP0_ACT_HI = 7;
  localparam int OB_CMP0_ACT_LO = 6;
  localparam int OB_CMP1_ACT_HI = 5;
  localparam int OB_CMP1_ACT_LO = 4;
  localparam int OB_WRAP_ACT_HI = 3;
  localparam int OB_WRAP_ACT_LO = 2;
  localparam int OB_WRAP_PULSE_EN = 1;
  localparam int OB_PRESET = 0;

  // Event flag fields
  localparam int FL_CAPTURE0 = 7;
  localparam int FL_CAPTURE1 = 6;
  localparam int FL_COMPARE0 = 5;
  localparam int FL_COMPARE1 = 4;
  localparam int FL_WRAP = 3;
  localparam int FL_CAP0_OVR = 2;
  localparam int FL_CMP0_OVR = 1;
  localparam int FL_AND_SELECT = 0;
  localparam int FL_LO = 1;
  localparam int FL_HI = 7;

  // Interrupt/DMA mask fields
  localparam int MK_GLOBAL_EN = 7;
  localparam int MK_CAP0_DMA = 6;
  localparam int MK_CAP0_IRQ = 5;
  localparam int MK_CAP1_IRQ = 4;
  localparam int MK_CMP0_DMA = 3;
  localparam int MK_CMP0_IRQ = 2;
  localparam int MK_CMP1_IRQ = 1;
  localparam int MK_WRAP_IRQ = 0;

  // DMA counter pointer fields
  localparam int DP_SWAP_BIT = 2;
  localparam int DP_DIRECTION = 1;
  localparam int DP_AREA = 0;

  // Pin A / swap control fields
  localparam int PS_SWAP_EN = 3;
  localparam int PS_PIN_A_PRESET = 0;

  typedef enum logic [1:0] {
    ACT_SET = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_RESET = 2'h2,
    ACT_NOP = 2'h3
  } tofc_action_type;
endpackage : tofc_pkg

//--- design/tofc_flag_if.sv
// Interface carrying set and clear requests to the sticky event flags.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface tofc_flag_if;
  import tofc_pkg::*;
  logic [FL_HI:FL_LO] hw_set;
  logic [FL_HI:FL_LO] sw_clr;
  logic [FL_HI:FL_LO] flags;
  modport ctrl (output hw_set, output sw_clr, input flags);
  modport store (input hw_set, input sw_clr, output flags);
endinterface : tofc_flag_if

//--- design/tofc_event_flags.sv
// Sticky event and overrun flags of the timer flag register.
// Assumes set and clear requests are single-cycle and synchronous to pclk.
`timescale 1ns/1ps
module tofc_event_flags (
  input wire logic pclk,
  input wire logic presetn,
  tofc_flag_if.store fl
);
  import tofc_pkg::*;

  genvar g;
  generate
    for (g = FL_LO; g <= FL_HI; g++) begin : g_flag
      logic flag_q;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_q <= RST_TIMER_EVENT_FLAGS[g];
        // Hardware set beats a clear in the same cycle
        end else if (fl.hw_set[g]) begin
          flag_q <= 1'b1;
        end else if (fl.sw_clr[g]) begin
          flag_q <= 1'b0;
        end
      end
      assign fl.flags[g] = flag_q;
    end
  endgenerate
endmodule : tofc_event_flags

//--- design/tofc_pin_action.sv
// Output pin B level: event actions combined, plus software preset.
// Assumes event strobes are one-cycle pulses from the timer core.
`timescale 1ns/1ps
module tofc_pin_action (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmp0_match,
  input wire logic cmp1_match,
  input wire logic wrap_event,
  input wire logic [1:0] cmp0_code,
  input wire logic [1:0] cmp1_code,
  input wire logic [1:0] wrap_code,
  input wire logic preset_we,
  input wire logic preset_level,
  output logic pin_q
);
  import tofc_pkg::*;

  logic [1:0] combined;
  logic any_event;
  tofc_action_type act;

  // R4 AND of codes
  always_comb begin
    combined = 2'h3;
    if (cmp0_match) begin
      combined = combined & cmp0_code;
    end
    if (cmp1_match) begin
      combined = combined & cmp1_code;
    end
    if (wrap_event) begin
      combined = combined & wrap_code;
    end
  end

  assign any_event = cmp0_match | cmp1_match | wrap_event;
  assign act = tofc_action_type'(combined);

  // R1 R2 R3 apply action; event beats a preset write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= RST_OUTPUT_B_CONTROL[OB_PRESET];
    end else if (any_event) begin
      unique case (act)
        ACT_SET: begin
          pin_q <= 1'b1;
        end
        ACT_TOGGLE: begin
          pin_q <= ~pin_q;
        end
        ACT_RESET: begin
          pin_q <= 1'b0;
        end
        ACT_NOP: begin
          pin_q <= pin_q;
        end
      endcase
    end else if (preset_we) begin
      // R6 preset write
      pin_q <= preset_level;
    end
  end
endmodule : tofc_pin_action

//--- design/tofc_top.sv
// Timer output B control, event flags, interrupt/DMA masks, DMA pointer.
// Assumes timer core strobes are one-cycle pulses on pclk; APB slave, no wait.
//
// Function
// R1 - Compare-0 match drives pin B per its two action bits.
// R2 - Compare-1 match drives pin B per its two action bits.
// R3 - Overflow or underflow drives pin B per its two action bits.
// R4 - Simultaneous events apply the bitwise AND of their action codes.
// R5 - With pulse enable set, each wrap gives a one-cycle on-chip pulse.
// R6 - Pin B preset bit: write presets the pin, read returns its level.
// R7 - Pin A preset bit: holds preset, read returns pin A level.
// R8 - Capture-0 flag set by capture, software clears, writing one captures.
// R9 - Capture-1 flag likewise; writing one captures except in bicapture.
// R10 - Combine bit picks OR or AND of capture events for interrupt.
// R11 - Compare-0 flag set on match; interrupts under global and own mask.
// R12 - Compare-1 flag set on match; interrupts under global and own mask.
// R13 - Wrap flag set on overflow; interrupts under global and own mask.
// R14 - Capture-0 overrun on repeated request or simulated capture.
// R15 - Compare-0 overrun on repeated request before flag cleared.
// R16 - Global enable low blocks all interrupts; high passes masked sources.
// R17 - Capture-0 DMA enable set by software, cleared at end of block.
// R18 - Under capture-0 DMA, its mask enables the end-of-block interrupt.
// R19 - Compare-0 DMA enable set by software, cleared at end of block.
// R20 - Under compare-0 DMA, its mask enables the end-of-block interrupt.
// R21 - Capture-1, compare-1 and wrap masks are plain read/write enables.
// R22 - Pointer bits 7:2 writable; swap mode may toggle bit 2.
// R23 - Hardware keeps direction bit: 0 capture source, 1 compare target.
// R24 - Pointer bit 0 selects memory or register file area.
// R25 - Swap enable puts both DMA channels into swap mode; here bit 2 toggles only while compare-0 DMA is enabled.
// R26 - Flags clear by writing zero; writing one elsewhere changes nothing.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module tofc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tofc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp0_match,
  input wire logic cmp1_match,
  input wire logic wrap_event,
  input wire logic capture0_event,
  input wire logic capture1_event,
  input wire logic bicapture_mode,
  input wire logic capture0_dma_eob,
  input wire logic compare0_dma_eob,
  input wire logic swap_table_toggle,
  input wire logic out_pin_a,
  output logic out_pin_b,
  output logic wrap_chip_pulse,
  output logic pin_a_preset_level,
  output logic pin_a_preset_load,
  output logic sw_capture0_load,
  output logic sw_capture1_load,
  output logic capture_irq,
  output logic compare0_irq,
  output logic compare1_irq,
  output logic wrap_irq,
  output logic capture0_dma_req,
  output logic compare0_dma_req,
  output logic [7:0] dma_counter_ptr,
  output logic swap_enable
);
  import tofc_pkg::*;

  tofc_flag_if fl ();

  logic [7:1] obc_q;
  logic and_select_q;
  logic [7:0] mask_q;
  logic [7:2] dma_counter_ptr_high_q;
  logic dma_direction_flag_q;
  logic dma_area_q;
  logic swap_enable_q;
  logic pin_a_preset_q;
  logic cap0_eob_pend_q;
  logic cmp0_eob_pend_q;
  logic wrap_chip_pulse_q;
  logic sw_cap0_q;
  logic sw_cap1_q;
  logic pin_a_load_q;
  logic [31:0] prdata_q;

  logic [7:0] idx;
  logic hit;
  logic wr;
  logic rd;
  logic wr_lane;
  logic [7:0] wd;
  logic wr_obc;
  logic wr_flags;
  logic wr_mask;
  logic wr_dcp;
  logic wr_pas;
  logic sw_cap0;
  logic sw_cap1;
  logic cap0_any;
  logic cap1_any;
  logic cap0_src;
  logic cmp0_src;
  logic cap0_term;
  logic cap1_term;
  logic [7:0] flags_rd;
  logic [7:0] obc_rd;
  logic [7:0] dcp_rd;

  // Address decode: word-aligned index, only byte lane 0 carries data
  assign idx = paddr[9:2];
  assign hit = (paddr[ADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
               ((idx == IDX_DMA_COUNTER_POINTER) || (idx == IDX_PIN_A_SWAP_CTRL) ||
                (idx == IDX_OUTPUT_B_CONTROL) || (idx == IDX_TIMER_EVENT_FLAGS) ||
                (idx == IDX_IRQ_DMA_MASK));
  assign wr = psel && penable && pwrite && hit;
  assign rd = psel && !penable && !pwrite;
  assign wr_lane = wr && pstrb[0];
  assign wd = pwdata[7:0];
  assign wr_obc = wr_lane && (idx == IDX_OUTPUT_B_CONTROL);
  assign wr_flags = wr_lane && (idx == IDX_TIMER_EVENT_FLAGS);
  assign wr_mask = wr_lane && (idx == IDX_IRQ_DMA_MASK);
  assign wr_dcp = wr_lane && (idx == IDX_DMA_COUNTER_POINTER);
  assign wr_pas = wr_lane && (idx == IDX_PIN_A_SWAP_CTRL);

  // Zero-wait slave; unmapped or misaligned access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  // R8 write one simulates capture 0
  assign sw_cap0 = wr_flags && wd[FL_CAPTURE0];
  // R9 write one captures on 1 unless bicapture
  assign sw_cap1 = wr_flags && wd[FL_CAPTURE1] && !bicapture_mode;
  assign cap0_any = capture0_event || sw_cap0;
  assign cap1_any = capture1_event || sw_cap1;

  // Output B control bits 7:1 are plain storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obc_q <= RST_OUTPUT_B_CONTROL[7:1];
    end else if (wr_obc) begin
      obc_q <= wd[7:1];
    end
  end

  tofc_pin_action u_pin_b (
    .pclk(pclk),
    .presetn(presetn),
    .cmp0_match(cmp0_match),
    .cmp1_match(cmp1_match),
    .wrap_event(wrap_event),
    .cmp0_code(obc_q[OB_CMP0_ACT_HI:OB_CMP0_ACT_LO]),
    .cmp1_code(obc_q[OB_CMP1_ACT_HI:OB_CMP1_ACT_LO]),
    .wrap_code(obc_q[OB_WRAP_ACT_HI:OB_WRAP_ACT_LO]),
    .preset_we(wr_obc),
    .preset_level(wd[OB_PRESET]),
    .pin_q(out_pin_b)
  );

  // R5 one pulse per wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_chip_pulse_q <= 1'b0;
    end else begin
      wrap_chip_pulse_q <= wrap_event && obc_q[OB_WRAP_PULSE_EN];
    end
  end
  assign wrap_chip_pulse = wrap_chip_pulse_q;

  // Sticky flag set and clear terms
  always_comb begin
    fl.hw_set = '0;
    // R8 capture 0 sets flag
    fl.hw_set[FL_CAPTURE0] = cap0_any;
    // R9 capture 1 sets flag
    fl.hw_set[FL_CAPTURE1] = cap1_any;
    // R11 compare 0 sets flag
    fl.hw_set[FL_COMPARE0] = cmp0_match;
    // R12 compare 1 sets flag
    fl.hw_set[FL_COMPARE1] = cmp1_match;
    // R13 wrap sets flag
    fl.hw_set[FL_WRAP] = wrap_event;
    // R14 repeated or simulated capture
    fl.hw_set[FL_CAP0_OVR] = sw_cap0 || (capture0_event && fl.flags[FL_CAPTURE0]);
    // R15 repeated compare request
    fl.hw_set[FL_CMP0_OVR] = cmp0_match && fl.flags[FL_COMPARE0];
  end

  // R26 zero clears
  assign fl.sw_clr = wr_flags ? ~wd[FL_HI:FL_LO] : '0;

  tofc_event_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fl(fl)
  );

  // R10 combine select storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      and_select_q <= RST_TIMER_EVENT_FLAGS[FL_AND_SELECT];
    end else if (wr_flags) begin
      and_select_q <= wd[FL_AND_SELECT];
    end
  end

  // R17 R19 DMA enables cleared by hardware at end of block; R21 plain masks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= RST_IRQ_DMA_MASK;
    end else begin
      if (wr_mask) begin
        mask_q <= wd;
      end
      if (capture0_dma_eob) begin
        mask_q[MK_CAP0_DMA] <= 1'b0;
      end
      if (compare0_dma_eob) begin
        mask_q[MK_CMP0_DMA] <= 1'b0;
      end
    end
  end

  // R18 R20 end-of-block pending, cleared with the event flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap0_eob_pend_q <= 1'b0;
      cmp0_eob_pend_q <= 1'b0;
    end else begin
      if (capture0_dma_eob && mask_q[MK_CAP0_DMA]) begin
        cap0_eob_pend_q <= 1'b1;
      end else if (fl.sw_clr[FL_CAPTURE0]) begin
        cap0_eob_pend_q <= 1'b0;
      end
      if (compare0_dma_eob && mask_q[MK_CMP0_DMA]) begin
        cmp0_eob_pend_q <= 1'b1;
      end else if (fl.sw_clr[FL_COMPARE0]) begin
        cmp0_eob_pend_q <= 1'b0;
      end
    end
  end

  // R17 R19 each event becomes a DMA request while enabled
  assign capture0_dma_req = capture0_event && mask_q[MK_CAP0_DMA];
  assign compare0_dma_req = cmp0_match && mask_q[MK_CMP0_DMA];

  // R18 per-capture interrupt replaced by end of block under DMA
  assign cap0_src = (fl.flags[FL_CAPTURE0] && !mask_q[MK_CAP0_DMA]) || cap0_eob_pend_q;
  // R20 per-match interrupt replaced by end of block under DMA
  assign cmp0_src = (fl.flags[FL_COMPARE0] && !mask_q[MK_CMP0_DMA]) || cmp0_eob_pend_q;
  assign cap0_term = cap0_src && mask_q[MK_CAP0_IRQ];
  assign cap1_term = fl.flags[FL_CAPTURE1] && mask_q[MK_CAP1_IRQ];

  // R10 R16 capture interrupt; AND needs both events, either mask
  assign capture_irq = mask_q[MK_GLOBAL_EN] &&
                       (and_select_q ? (cap0_src && fl.flags[FL_CAPTURE1] &&
                                        (mask_q[MK_CAP0_IRQ] || mask_q[MK_CAP1_IRQ]))
                                     : (cap0_term || cap1_term));
  // R11 R16 compare 0
  assign compare0_irq = mask_q[MK_GLOBAL_EN] && mask_q[MK_CMP0_IRQ] && cmp0_src;
  // R12 R16 compare 1
  assign compare1_irq = mask_q[MK_GLOBAL_EN] && mask_q[MK_CMP1_IRQ] &&
                        fl.flags[FL_COMPARE1];
  // R13 R16 wrap
  assign wrap_irq = mask_q[MK_GLOBAL_EN] && mask_q[MK_WRAP_IRQ] && fl.flags[FL_WRAP];

  // R22 R24 software fields; swap toggle inverts the bit 2 written in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_counter_ptr_high_q <= RST_DMA_COUNTER_POINTER[7:2];
      dma_area_q <= RST_DMA_COUNTER_POINTER[DP_AREA];
    end else begin
      if (wr_dcp) begin
        dma_counter_ptr_high_q <= wd[7:2];
        dma_area_q <= wd[DP_AREA];
      end
      // R22 swap toggles bit 2
      if (swap_table_toggle && swap_enable_q && mask_q[MK_CMP0_DMA]) begin
        dma_counter_ptr_high_q[DP_SWAP_BIT] <=
          ~(wr_dcp ? wd[DP_SWAP_BIT] : dma_counter_ptr_high_q[DP_SWAP_BIT]);
      end
    end
  end

  // R23 direction follows the last DMA request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_direction_flag_q <= RST_DMA_COUNTER_POINTER[DP_DIRECTION];
    end else if (compare0_dma_req) begin
      dma_direction_flag_q <= 1'b1;
    end else if (capture0_dma_req) begin
      dma_direction_flag_q <= 1'b0;
    end
  end

  assign dcp_rd = {dma_counter_ptr_high_q, dma_direction_flag_q, dma_area_q};
  assign dma_counter_ptr = dcp_rd;

  // R25 swap enable; R7 pin A preset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_enable_q <= RST_PIN_A_SWAP_CTRL[PS_SWAP_EN];
      pin_a_preset_q <= RST_PIN_A_SWAP_CTRL[PS_PIN_A_PRESET];
    end else if (wr_pas) begin
      swap_enable_q <= wd[PS_SWAP_EN];
      pin_a_preset_q <= wd[PS_PIN_A_PRESET];
    end
  end
  assign swap_enable = swap_enable_q;
  assign pin_a_preset_level = pin_a_preset_q;

  // One-cycle strobes toward the timer core, registered for clean timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cap0_q <= 1'b0;
      sw_cap1_q <= 1'b0;
      pin_a_load_q <= 1'b0;
    end else begin
      sw_cap0_q <= sw_cap0;
      sw_cap1_q <= sw_cap1;
      pin_a_load_q <= wr_pas;
    end
  end
  assign sw_capture0_load = sw_cap0_q;
  assign sw_capture1_load = sw_cap1_q;
  assign pin_a_preset_load = pin_a_load_q;

  // R6 read returns pin B
  assign obc_rd = {obc_q, out_pin_b};
  assign flags_rd = {fl.flags, and_select_q};

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd) begin
      unique case (idx)
        IDX_DMA_COUNTER_POINTER: begin
          prdata_q <= {24'h00_0000, dcp_rd};
        end
        IDX_PIN_A_SWAP_CTRL: begin
          // R7 read returns pin A
          prdata_q <= {28'h000_0000, swap_enable_q, 2'h0, out_pin_a};
        end
        IDX_OUTPUT_B_CONTROL: begin
          prdata_q <= {24'h00_0000, obc_rd};
        end
        IDX_TIMER_EVENT_FLAGS: begin
          prdata_q <= {24'h00_0000, flags_rd};
        end
        IDX_IRQ_DMA_MASK: begin
          prdata_q <= {24'h00_0000, mask_q};
        end
        default: begin
          prdata_q <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule : tofc_top

//--- tb/tofc_checker_assertions.sv
// Port-level assertions for the timer output, flag and mask block.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/1ps
module tofc_checker
  import tofc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmp0_match,
  input wire logic cmp1_match,
  input wire logic wrap_event,
  input wire logic compare0_dma_eob,
  input wire logic out_pin_b,
  input wire logic wrap_chip_pulse,
  input wire logic sw_capture0_load,
  input wire logic compare0_irq,
  input wire logic wrap_irq,
  input wire logic compare0_dma_req,
  input wire logic capture0_dma_req,
  input wire logic [7:0] dma_counter_ptr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_bad_addr_err: assert property (psel && penable && paddr == 12'h100 |-> pslverr)
    else $error("unmapped access not flagged");
  a_pin_b_cause: assert property (
    $changed(out_pin_b) |-> $past(cmp0_match || cmp1_match || wrap_event || (psel && penable && pwrite)))
    else $error("pin B moved without cause");
  a_wrap_pulse_src: assert property (wrap_chip_pulse |-> $past(wrap_event))
    else $error("on-chip pulse without wrap");
  a_wrap_pulse_one: assert property (wrap_chip_pulse && !wrap_event |=> !wrap_chip_pulse)
    else $error("on-chip pulse too long");
  a_cap0_load_src: assert property (
    sw_capture0_load |-> $past(psel && penable && pwrite && pwdata[7] && paddr == 12'h3f8))
    else $error("capture load without write of one");
  a_cmp0_irq_cause: assert property (
    $rose(compare0_irq) |-> $past(cmp0_match || compare0_dma_eob || (psel && penable)))
    else $error("compare interrupt without cause");
  a_wrap_irq_cause: assert property (
    $rose(wrap_irq) |-> $past(wrap_event || (psel && penable && pwrite)))
    else $error("wrap interrupt without cause");
  a_dma_req_src: assert property (compare0_dma_req |-> cmp0_match)
    else $error("compare DMA request without match");
  a_dir_compare: assert property (compare0_dma_req |=> dma_counter_ptr[1])
    else $error("direction not set by compare DMA");
  a_dir_capture: assert property (
    capture0_dma_req && !compare0_dma_req |=> !dma_counter_ptr[1])
    else $error("direction not cleared by capture DMA");
endmodule : tofc_checker

//--- tb/tofc_timer_model.sv
// Model of the timer core strobes, pin A and the DMA controller.
// Assumes the bench calls its tasks from one process between edges.
`timescale 1ns/1ps
module tofc_timer_model #(
  parameter int BLK = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture0_dma_req,
  input wire logic compare0_dma_req,
  output logic cmp0_match,
  output logic cmp1_match,
  output logic wrap_event,
  output logic capture0_event,
  output logic capture1_event,
  output logic swap_table_toggle,
  output logic out_pin_a,
  output logic capture0_dma_eob,
  output logic compare0_dma_eob
);
  logic [5:0] ev_q = '0;
  logic [1:0] eob_q = '0;
  logic pin_a_q = 1'b1;
  int cap_n;
  int cmp_n;
  assign {swap_table_toggle, capture1_event, capture0_event} = ev_q[5:3];
  assign {wrap_event, cmp1_match, cmp0_match} = ev_q[2:0];
  assign {capture0_dma_eob, compare0_dma_eob} = eob_q;
  assign out_pin_a = pin_a_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_n <= 0;
      cmp_n <= 0;
      eob_q <= '0;
    end else begin
      eob_q <= {capture0_dma_req && cap_n == BLK - 1, compare0_dma_req && cmp_n == BLK - 1};
      if (capture0_dma_req) cap_n <= (cap_n == BLK - 1) ? 0 : cap_n + 1;
      if (compare0_dma_req) cmp_n <= (cmp_n == BLK - 1) ? 0 : cmp_n + 1;
    end
  end
  // One-cycle strobes, as the timer core gives them
  task automatic pulse(input logic [5:0] e);
    @(posedge pclk);
    ev_q <= e;
    @(posedge pclk);
    ev_q <= '0;
    #1;
  endtask : pulse
  task automatic set_pin_a(input logic v);
    @(posedge pclk);
    pin_a_q <= v;
  endtask : set_pin_a
endmodule : tofc_timer_model

//--- tb/tofc_top_tb_top.sv
// Self-checking bench: APB register tasks and timer event scenarios.
// Assumes the checker and the timer model files are compiled first.
`timescale 1ns/1ps
module tofc_top_tb_top;
  import tofc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bicapture_mode = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] rdat, ob, dma_counter_ptr;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, last_err, out_pin_a, swap_table_toggle, out_pin_b, wrap_chip_pulse;
  logic cmp0_match, cmp1_match, wrap_event, capture0_event, capture1_event, swap_enable;
  logic capture0_dma_eob, compare0_dma_eob, pin_a_preset_level, sw_capture0_load;
  logic sw_capture1_load, capture_irq, compare0_irq, compare1_irq, wrap_irq;
  logic capture0_dma_req, compare0_dma_req;
  int err_total = 0, comparisons = 0, cycles = 0, n_pulse = 0, n_load1 = 0;
  always #2.5 pclk = ~pclk;
  tofc_top i_tofc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .cmp0_match, .cmp1_match, .wrap_event,
    .capture0_event, .capture1_event, .bicapture_mode, .capture0_dma_eob, .compare0_dma_eob,
    .swap_table_toggle, .out_pin_a, .out_pin_b, .wrap_chip_pulse, .pin_a_preset_level,
    .pin_a_preset_load(), .sw_capture0_load, .sw_capture1_load, .capture_irq, .compare0_irq,
    .compare1_irq, .wrap_irq, .capture0_dma_req, .compare0_dma_req, .dma_counter_ptr,
    .swap_enable);
  tofc_timer_model #(.BLK(2)) i_tofc_timer_model (.pclk, .presetn, .capture0_dma_req,
    .compare0_dma_req, .cmp0_match, .cmp1_match, .wrap_event, .capture0_event,
    .capture1_event, .swap_table_toggle, .out_pin_a, .capture0_dma_eob, .compare0_dma_eob);
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cycles++;
    if (wrap_chip_pulse === 1'b1) n_pulse++;
    if (sw_capture1_load === 1'b1) n_load1++;
    if (cycles == 3000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  // Holds the request until pready is seen high at a rising edge
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk8($sformatf("reg %h", a), e, rdat);
  endtask : rd
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h3f4, RST_OUTPUT_B_CONTROL);
    rd(12'h3f8, RST_TIMER_EVENT_FLAGS);
    rd(12'h3fc, RST_IRQ_DMA_MASK);
    rd(12'h3c0, RST_DMA_COUNTER_POINTER);
    rd(12'h100, 8'h00);
    chk1("slverr", 1'b1, last_err);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 4; c++) begin
        ob = (8'hfc & ~(8'h03 << (6 - 2 * k))) | 8'(c << (6 - 2 * k)) | 8'h01;
        wr(12'h3f4, ob);
        i_tofc_timer_model.pulse(6'(1 << k));
        rd(12'h3f4, {ob[7:1], c == 0 || c == 3});
        chk1("pin_b", c == 0 || c == 3, out_pin_b);
      end
    end
    wr(12'h3f4, 8'h6c);
    i_tofc_timer_model.pulse(6'h07);
    rd(12'h3f4, 8'h6d);
    chk8("pulses", 8'd0, 8'(n_pulse));
    wr(12'h3f4, 8'hfe);
    i_tofc_timer_model.pulse(6'h04);
    wr(12'h3f8, 8'h00);
    chk8("pulses", 8'd1, 8'(n_pulse));
    $display("test pin actions done");
    i_tofc_timer_model.pulse(6'h17);
    rd(12'h3f8, 8'h78);
    wr(12'h3fc, 8'h87);
    chk8("irqs", 8'h07, {5'h0, compare0_irq, compare1_irq, wrap_irq});
    wr(12'h3fc, 8'h07);
    chk8("irqs", 8'h00, {5'h0, compare0_irq, compare1_irq, wrap_irq});
    i_tofc_timer_model.pulse(6'h01);
    rd(12'h3f8, 8'h7a);
    wr(12'h3f8, 8'h00);
    rd(12'h3f8, 8'h00);
    wr(12'h3f8, 8'hfe);
    rd(12'h3f8, 8'hc4);
    wr(12'h3fc, 8'hb0);
    chk1("cap_irq", 1'b1, capture_irq);
    wr(12'h3f8, 8'h41);
    chk1("cap_irq", 1'b0, capture_irq);
    i_tofc_timer_model.pulse(6'h08);
    rd(12'h3f8, 8'hc1);
    chk1("cap_irq", 1'b1, capture_irq);
    bicapture_mode <= 1'b1;
    wr(12'h3f8, 8'h41);
    bicapture_mode <= 1'b0;
    wr(12'h3f8, 8'h00);
    chk8("loads1", 8'd2, 8'(n_load1));
    $display("test flags done");
    wr(12'h3fc, 8'h8c);
    i_tofc_timer_model.pulse(6'h01);
    chk1("cmp0_irq", 1'b0, compare0_irq);
    rd(12'h3c0, 8'h02);
    i_tofc_timer_model.pulse(6'h01);
    rd(12'h3fc, 8'h84);
    chk1("cmp0_irq", 1'b1, compare0_irq);
    wr(12'h3fc, 8'he0);
    i_tofc_timer_model.pulse(6'h08);
    chk1("cap_irq", 1'b0, capture_irq);
    i_tofc_timer_model.pulse(6'h08);
    rd(12'h3fc, 8'ha0);
    chk1("cap_irq", 1'b1, capture_irq);
    pstrb <= 4'h0;
    wr(12'h3c0, 8'hff);
    pstrb <= 4'hf;
    rd(12'h3c0, 8'h00);
    $display("test dma done");
    wr(12'h3c0, 8'hff);
    rd(12'h3c0, 8'hfd);
    wr(12'h3c4, 8'h09);
    chk1("swap_en", 1'b1, swap_enable);
    chk1("pin_a_lvl", 1'b1, pin_a_preset_level);
    wr(12'h3fc, 8'h08);
    i_tofc_timer_model.pulse(6'h20);
    rd(12'h3c0, 8'hf9);
    i_tofc_timer_model.set_pin_a(1'b0);
    rd(12'h3c4, 8'h08);
    $display("test pointer done");
    summarize();
  end
endmodule : tofc_top_tb_top

bind tofc_top tofc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .cmp0_match, .cmp1_match, .wrap_event, .out_pin_b, .wrap_chip_pulse,
  .sw_capture0_load, .compare0_irq, .wrap_irq, .compare0_dma_req, .capture0_dma_req,
  .dma_counter_ptr, .compare0_dma_eob);
